// ---- verilog/tws_pkg.sv ----
// ************************************************************
// Shared constants
// ************************************************************
package tws_pkg;
	localparam int BYTE_W = 8;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam int TYPE_HI = 7;
	localparam int TYPE_LO = 4;
	localparam int TGT_HI = 3;
	localparam int TGT_LO = 1;
	localparam int RW_BIT = 0;
	localparam logic [2:0] TGT_MEM = 3'h0;
	localparam logic [2:0] TGT_CTRL = 3'h2;
	localparam logic [2:0] TGT_POT = 3'h7;
	localparam logic RW_READ = 1'b1;
	localparam logic ACK_LEVEL = 1'b0;
	localparam logic STANDBY_RST = 1'b1;
	localparam logic [7:0] TX_BUF_RST = 8'h00;

	// ************************************************************
	// Link state machine
	// ************************************************************
	typedef enum logic [5:0] {
		ST_IDLE = 6'h01,
		ST_ADDR = 6'h02,
		ST_WACK = 6'h04,
		ST_WRX = 6'h08,
		ST_RTX = 6'h10,
		ST_RACK = 6'h20
	} tws_state_t;
endpackage

// ---- verilog/tws_sync2.sv ----
`timescale 1ns/10ps
// ************************************************************
// Two-stage level synchroniser
// ************************************************************
module tws_sync2 #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] s1_reg;
	logic [W-1:0] s2_reg;
	logic [W-1:0] s1_next;
	logic [W-1:0] s2_next;

	always_comb begin
		s1_next = d;
		s2_next = s1_reg;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s1_reg <= '0;
			s2_reg <= '0;
		end else begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
		end
	end

	assign q = s2_reg;
endmodule

// ---- verilog/tws_toggle_sync.sv ----
`timescale 1ns/10ps
// ************************************************************
// Toggle event crossing, one pulse per toggle
// ************************************************************
module tws_toggle_sync (
	input wire logic clk,
	input wire logic reset,
	input wire logic tgl,
	output logic pulse
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic s1_next;
	logic s2_next;
	logic s3_next;

	always_comb begin
		s1_next = tgl;
		s2_next = s1_reg;
		s3_next = s2_reg;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			s3_reg <= s3_next;
		end
	end

	assign pulse = s2_reg ^ s3_reg;
endmodule

// ---- verilog/tws_slave.sv ----
`timescale 1ns/10ps
module tws_slave #(
	// Arbitrary identifier value
	parameter logic [3:0] DEV_TYPE_ID = 4'h5
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic scl_link,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe,
	input wire logic write_busy,
	input wire logic [7:0] tx_data,
	input wire logic tx_valid,
	output logic tx_req,
	output logic [7:0] rx_data,
	output logic rx_valid,
	output logic [2:0] addr_target,
	output logic addr_read,
	output logic addr_valid,
	output logic sel_memory,
	output logic sel_control,
	output logic sel_pots,
	output logic txn_start,
	output logic txn_end,
	output logic standby
);
	// ************************************************************
	// Link domain, rising edge: sampling
	// ************************************************************
	tws_pkg::tws_state_t state_reg;
	tws_pkg::tws_state_t state_next;
	logic sda_pos_reg;
	logic sda_pos_next;
	logic [7:0] sh_reg;
	logic [7:0] sh_next;
	logic mack_reg;
	logic mack_next;
	logic busy_link;

	tws_sync2 #(.W(1)) u_busy_sync (
		.clk(scl_link),
		.reset(reset),
		.d(write_busy),
		.q(busy_link)
	);

	always_comb begin
		sda_pos_next = sda_in;
		sh_next = sh_reg;
		mack_next = mack_reg;
		if (state_reg == tws_pkg::ST_ADDR || state_reg == tws_pkg::ST_WRX) begin
			sh_next = {sh_reg[6:0], sda_in};
		end
		if (state_reg == tws_pkg::ST_RACK) begin
			mack_next = sda_in;
		end
	end

	always_ff @(posedge scl_link or posedge reset) begin
		if (reset) begin
			sh_reg <= 8'h00;
			mack_reg <= 1'b1;
		end else begin
			sh_reg <= sh_next;
			mack_reg <= mack_next;
		end
	end

	// ************************************************************
	// Link domain, falling edge: sequencing and drive
	// ************************************************************
	logic [2:0] cnt_reg;
	logic [2:0] cnt_next;
	logic oe_reg;
	logic oe_next;
	logic is_read_reg;
	logic is_read_next;
	logic [7:0] tx_sh_reg;
	logic [7:0] tx_sh_next;
	logic [7:0] rx_hold_reg;
	logic [7:0] rx_hold_next;
	logic rx_tgl_reg;
	logic rx_tgl_next;
	logic addr_tgl_reg;
	logic addr_tgl_next;
	logic take_tgl_reg;
	logic take_tgl_next;
	logic [7:0] tx_buf_reg;
	logic type_match;

	assign type_match = sh_reg[tws_pkg::TYPE_HI:tws_pkg::TYPE_LO] == DEV_TYPE_ID;

	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		oe_next = oe_reg;
		is_read_next = is_read_reg;
		tx_sh_next = tx_sh_reg;
		rx_hold_next = rx_hold_reg;
		rx_tgl_next = rx_tgl_reg;
		addr_tgl_next = addr_tgl_reg;
		take_tgl_next = take_tgl_reg;
		if (sda_pos_reg && !sda_in) begin
			// Data fell during the high phase just ended
			state_next = tws_pkg::ST_ADDR;
			cnt_next = 3'h0;
			oe_next = 1'b0;
			is_read_next = 1'b0;
		end else begin
			case (state_reg)
				tws_pkg::ST_IDLE: begin
					oe_next = 1'b0;
				end
				tws_pkg::ST_ADDR: begin
					if (cnt_reg != tws_pkg::BIT_LAST) begin
						cnt_next = cnt_reg + 3'h1;
					end else if (type_match && !busy_link) begin
						oe_next = 1'b1;
						is_read_next = sh_reg[tws_pkg::RW_BIT] == tws_pkg::RW_READ;
						rx_hold_next = sh_reg;
						addr_tgl_next = !addr_tgl_reg;
						state_next = tws_pkg::ST_WACK;
					end else begin
						state_next = tws_pkg::ST_IDLE;
					end
				end
				tws_pkg::ST_WRX: begin
					if (cnt_reg != tws_pkg::BIT_LAST) begin
						cnt_next = cnt_reg + 3'h1;
					end else begin
						oe_next = 1'b1;
						rx_hold_next = sh_reg;
						rx_tgl_next = !rx_tgl_reg;
						state_next = tws_pkg::ST_WACK;
					end
				end
				tws_pkg::ST_WACK: begin
					oe_next = 1'b0;
					cnt_next = 3'h0;
					if (is_read_reg) begin
						tx_sh_next = tx_buf_reg;
						oe_next = !tx_buf_reg[7];
						take_tgl_next = !take_tgl_reg;
						state_next = tws_pkg::ST_RTX;
					end else begin
						state_next = tws_pkg::ST_WRX;
					end
				end
				tws_pkg::ST_RTX: begin
					if (cnt_reg != tws_pkg::BIT_LAST) begin
						cnt_next = cnt_reg + 3'h1;
						tx_sh_next = {tx_sh_reg[6:0], 1'b0};
						oe_next = !tx_sh_reg[6];
					end else begin
						oe_next = 1'b0;
						state_next = tws_pkg::ST_RACK;
					end
				end
				tws_pkg::ST_RACK: begin
					cnt_next = 3'h0;
					if (mack_reg == tws_pkg::ACK_LEVEL) begin
						tx_sh_next = tx_buf_reg;
						oe_next = !tx_buf_reg[7];
						take_tgl_next = !take_tgl_reg;
						state_next = tws_pkg::ST_RTX;
					end else begin
						oe_next = 1'b0;
						state_next = tws_pkg::ST_IDLE;
					end
				end
				default: begin
					oe_next = 1'b0;
					state_next = tws_pkg::ST_IDLE;
				end
			endcase
		end
	end

	always_ff @(negedge scl_link or posedge reset) begin
		if (reset) begin
			state_reg <= tws_pkg::ST_IDLE;
			cnt_reg <= 3'h0;
			oe_reg <= 1'b0;
			is_read_reg <= 1'b0;
			tx_sh_reg <= 8'h00;
			rx_hold_reg <= 8'h00;
			rx_tgl_reg <= 1'b0;
			addr_tgl_reg <= 1'b0;
			take_tgl_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			oe_reg <= oe_next;
			is_read_reg <= is_read_next;
			tx_sh_reg <= tx_sh_next;
			rx_hold_reg <= rx_hold_next;
			rx_tgl_reg <= rx_tgl_next;
			addr_tgl_reg <= addr_tgl_next;
			take_tgl_reg <= take_tgl_next;
		end
	end

	// Open-drain: only ever pulls low; released before stop
	assign sda_out = 1'b0;
	assign sda_oe = oe_reg;

	// ************************************************************
	// System domain: line watch and user side
	// ************************************************************
	logic scl_s;
	logic sda_s;
	logic read_s;
	logic rx_pulse;
	logic addr_pulse;
	logic take_pulse;
	logic start_det;
	logic stop_det;

	tws_sync2 #(.W(3)) u_line_sync (
		.clk(clk),
		.reset(reset),
		.d({scl_link, sda_in, is_read_reg}),
		.q({scl_s, sda_s, read_s})
	);

	tws_toggle_sync u_rx_evt (
		.clk(clk),
		.reset(reset),
		.tgl(rx_tgl_reg),
		.pulse(rx_pulse)
	);

	tws_toggle_sync u_addr_evt (
		.clk(clk),
		.reset(reset),
		.tgl(addr_tgl_reg),
		.pulse(addr_pulse)
	);

	tws_toggle_sync u_take_evt (
		.clk(clk),
		.reset(reset),
		.tgl(take_tgl_reg),
		.pulse(take_pulse)
	);

	logic sda_prev_reg;
	logic sda_prev_next;
	logic standby_reg;
	logic standby_next;
	logic start_reg;
	logic start_next;
	logic end_reg;
	logic end_next;
	logic [7:0] rx_data_reg;
	logic [7:0] rx_data_next;
	logic rx_valid_reg;
	logic rx_valid_next;
	logic [2:0] tgt_reg;
	logic [2:0] tgt_next;
	logic aread_reg;
	logic aread_next;
	logic avalid_reg;
	logic avalid_next;
	logic [2:0] sel_reg;
	logic [2:0] sel_next;
	logic [7:0] tx_buf_next;
	logic tx_req_reg;
	logic tx_req_next;
	logic boot_reg;
	logic boot_next;
	logic scl_prev_reg;
	logic scl_prev_next;

	// Clock high in both samples, so data changes in the low phase never look like start or stop
	assign start_det = scl_s && scl_prev_reg && sda_prev_reg && !sda_s;
	assign stop_det = scl_s && scl_prev_reg && !sda_prev_reg && sda_s;

	always_comb begin
		sda_prev_next = sda_s;
		scl_prev_next = scl_s;
		start_next = start_det;
		end_next = stop_det;
		standby_next = standby_reg;
		if (start_det) begin
			standby_next = 1'b0;
		end else if (stop_det && read_s) begin
			standby_next = 1'b1;
		end
		rx_data_next = rx_data_reg;
		rx_valid_next = rx_pulse;
		if (rx_pulse) begin
			rx_data_next = rx_hold_reg;
		end
		tgt_next = tgt_reg;
		aread_next = aread_reg;
		sel_next = sel_reg;
		avalid_next = addr_pulse;
		if (addr_pulse) begin
			tgt_next = rx_hold_reg[tws_pkg::TGT_HI:tws_pkg::TGT_LO];
			aread_next = rx_hold_reg[tws_pkg::RW_BIT] == tws_pkg::RW_READ;
			sel_next = {tgt_next == tws_pkg::TGT_POT, tgt_next == tws_pkg::TGT_CTRL,
				tgt_next == tws_pkg::TGT_MEM};
		end
		tx_buf_next = tx_buf_reg;
		if (tx_valid) begin
			tx_buf_next = tx_data;
		end
		boot_next = 1'b0;
		tx_req_next = take_pulse || boot_reg;
	end

	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			sda_prev_reg <= 1'b1;
			scl_prev_reg <= 1'b0;
			standby_reg <= tws_pkg::STANDBY_RST;
			start_reg <= 1'b0;
			end_reg <= 1'b0;
			rx_data_reg <= 8'h00;
			rx_valid_reg <= 1'b0;
			tgt_reg <= 3'h0;
			aread_reg <= 1'b0;
			avalid_reg <= 1'b0;
			sel_reg <= 3'h0;
			tx_buf_reg <= tws_pkg::TX_BUF_RST;
			tx_req_reg <= 1'b0;
			boot_reg <= 1'b1;
		end else begin
			sda_prev_reg <= sda_prev_next;
			scl_prev_reg <= scl_prev_next;
			standby_reg <= standby_next;
			start_reg <= start_next;
			end_reg <= end_next;
			rx_data_reg <= rx_data_next;
			rx_valid_reg <= rx_valid_next;
			tgt_reg <= tgt_next;
			aread_reg <= aread_next;
			avalid_reg <= avalid_next;
			sel_reg <= sel_next;
			tx_buf_reg <= tx_buf_next;
			tx_req_reg <= tx_req_next;
			boot_reg <= boot_next;
		end
	end

	// Stop presets the sampled data level high; the clock rests high until the next start
	logic pos_set;
	assign pos_set = reset || end_reg;

	always_ff @(posedge scl_link or posedge pos_set) begin
		if (pos_set) begin
			sda_pos_reg <= 1'b1;
		end else begin
			sda_pos_reg <= sda_pos_next;
		end
	end

	assign tx_req = tx_req_reg;
	assign rx_data = rx_data_reg;
	assign rx_valid = rx_valid_reg;
	assign addr_target = tgt_reg;
	assign addr_read = aread_reg;
	assign addr_valid = avalid_reg;
	assign sel_memory = sel_reg[0];
	assign sel_control = sel_reg[1];
	assign sel_pots = sel_reg[2];
	assign txn_start = start_reg;
	assign txn_end = end_reg;
	assign standby = standby_reg;
endmodule

// ---- tb/tws_slave_sva.sv ----
`timescale 1ns/10ps
// ********
// Link checker
// ********
module tws_slave_sva (
	input wire logic clk,
	input wire logic reset,
	input wire logic scl_link,
	input wire logic sda_in,
	input wire logic sda_oe,
	input wire logic write_busy,
	input wire logic [7:0] rx_data,
	input wire logic rx_valid,
	input wire logic [2:0] addr_target,
	input wire logic addr_valid,
	input wire logic sel_memory,
	input wire logic sel_control,
	input wire logic sel_pots,
	input wire logic txn_start,
	input wire logic txn_end,
	input wire logic standby
);
	a_oe_after_reset: assert property (
		@(posedge clk) disable iff (reset) $past(reset) |-> !sda_oe)
		else $error("data driven after reset");
	a_oe_scl_high: assert property (
		@(posedge clk) disable iff (reset) scl_link && $past(scl_link) |-> $stable(sda_oe))
		else $error("data moved with clock high");
	a_start_seen: assert property (
		@(posedge clk) disable iff (reset) scl_link && $past(scl_link) && $fell(sda_in) |-> ##[1:5] txn_start)
		else $error("start missed");
	a_stop_seen: assert property (
		@(posedge clk) disable iff (reset) scl_link && $past(scl_link) && $rose(sda_in) |-> ##[1:5] txn_end)
		else $error("stop missed");
	a_standby_cause: assert property (
		@(posedge clk) disable iff (reset) $rose(standby) |-> txn_end || $past(txn_end))
		else $error("standby without stop");
	a_ack_len: assert property (
		@(posedge scl_link) disable iff (reset) sda_oe [*8] ##1 sda_oe |=> !sda_oe)
		else $error("data held too long");
	a_sel_decode: assert property (
		@(posedge clk) disable iff (reset) addr_valid |=> sel_memory == (addr_target == tws_pkg::TGT_MEM)
		&& sel_control == (addr_target == tws_pkg::TGT_CTRL) && sel_pots == (addr_target == tws_pkg::TGT_POT))
		else $error("target decode wrong");
	a_rx_pulse: assert property (
		@(posedge clk) disable iff (reset) rx_valid |=> !rx_valid && $stable(rx_data))
		else $error("rx pulse wrong");
	a_busy_noack: assert property (
		@(posedge clk) disable iff (reset) write_busy && $past(write_busy, 40) |-> !addr_valid)
		else $error("address taken while busy");
	c_start: cover property (@(posedge clk) txn_start);
	c_rx: cover property (@(posedge clk) rx_valid);
	c_standby: cover property (@(posedge clk) $rose(standby));
endmodule

bind tws_slave tws_slave_sva i_sva (.clk, .reset, .scl_link, .sda_in, .sda_oe, .write_busy, .rx_data,
	.rx_valid, .addr_target, .addr_valid, .sel_memory, .sel_control, .sel_pots, .txn_start, .txn_end, .standby);

// ---- tb/tws_master_model.sv ----
`timescale 1ns/10ps
// ********
// Bus master, open-drain data
// ********
module tws_master_model (
	output logic scl,
	output logic m_oe,
	input wire logic sda
);
	initial begin
		scl = 1'b1;
		m_oe = 1'b0;
	end
	task automatic bit_io(input logic b, output logic s);
		#40;
		m_oe = !b;
		#40;
		scl = 1'b1;
		#40;
		s = sda;
		#40;
		scl = 1'b0;
	endtask
	task automatic start();
		#40;
		m_oe = 1'b0;
		#40;
		scl = 1'b1;
		// Long phases so the sampled line watcher sees the clock high around the edge
		#120;
		m_oe = 1'b1;
		#120;
		scl = 1'b0;
	endtask
	task automatic stop();
		#40;
		m_oe = 1'b1;
		#40;
		scl = 1'b1;
		#120;
		m_oe = 1'b0;
		#120;
	endtask
	task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q, output logic a);
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], q[i]);
		end
		bit_io(ak, a);
	endtask
endmodule

// ---- tb/two_wire_serial_slave_tb.sv ----
`timescale 1ns/10ps
// ********
// Slave bench
// ********
module two_wire_serial_slave_tb;
	localparam logic [3:0] ID = 4'h9; // Arbitrary identifier value
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic write_busy = 1'b0;
	logic [7:0] tx_data = 8'h00;
	logic tx_valid = 1'b0;
	logic scl, m_oe, sda_out, sda_oe, tx_req, rx_valid, addr_read, addr_valid;
	logic sel_memory, sel_control, sel_pots, txn_start, txn_end, standby, a;
	logic [7:0] rx_data, q;
	logic [2:0] addr_target;
	logic [2:0] tg[3] = '{3'h0, 3'h2, 3'h7};
	logic [7:0] pool[16];
	logic [7:0] ldq[$], expd[$], rxq[$], expa[$], adq[$];
	wire sda = !m_oe && (sda_oe ? sda_out : 1'b1);
	int miscompares = 0;
	int compares = 0;
	int n_st = 0;
	int n_en = 0;
	int es = 0;
	int ee = 0;
	int n_ld = 0;
	always #25 clk = ~clk;
	tws_slave #(.DEV_TYPE_ID(ID)) i_dut (.clk, .reset, .scl_link(scl), .sda_in(sda), .sda_out, .sda_oe,
		.write_busy, .tx_data, .tx_valid, .tx_req, .rx_data, .rx_valid, .addr_target, .addr_read,
		.addr_valid, .sel_memory, .sel_control, .sel_pots, .txn_start, .txn_end, .standby);
	tws_master_model i_mst (.scl, .m_oe, .sda);
	always @(negedge clk) begin
		tx_valid <= 1'b0;
		if (tx_req === 1'b1) begin
			tx_data <= pool[n_ld % 16];
			tx_valid <= 1'b1;
			ldq.push_back(pool[n_ld % 16]);
			n_ld++;
		end
		if (rx_valid === 1'b1) rxq.push_back(rx_data);
		if (addr_valid === 1'b1) adq.push_back({1'b0, sel_pots, sel_control, sel_memory, addr_target, addr_read});
		if (txn_start === 1'b1) n_st++;
		if (txn_end === 1'b1) n_en++;
	end
	task automatic chk(input logic [7:0] g, input logic [7:0] e);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("BAD %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic addr(input logic [3:0] id, input logic [2:0] t, input logic rw, input logic ok);
		i_mst.start();
		es++;
		i_mst.xfer({id, t, rw}, 1'b1, q, a);
		chk({7'h00, a}, {7'h00, !ok});
		if (ok) expa.push_back({1'b0, t == 3'h7, t == 3'h2, t == 3'h0, t, rw});
	endtask
	task automatic wr(input logic [7:0] d, input logic ok);
		i_mst.xfer(d, 1'b1, q, a);
		chk({7'h00, a}, {7'h00, !ok});
		if (ok) expd.push_back(d);
	endtask
	task automatic rd(input logic nk);
		i_mst.xfer(8'hff, nk, q, a);
		chk(q, ldq.pop_front());
	endtask
	task automatic fin();
		i_mst.stop();
		ee++;
	endtask
	task automatic wrap_up();
		if (miscompares == 0 && compares > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		#500000;
		miscompares++;
		wrap_up();
	end
	initial begin
		void'($urandom(32'h187f_5a42));
		foreach (pool[i]) pool[i] = 8'($urandom);
		repeat (3) @(negedge clk);
		reset = 1'b0;
		repeat (4) @(negedge clk);
		chk({7'h00, sda_oe}, 8'h00);
		chk({7'h00, standby}, 8'h01);
		foreach (tg[i]) begin
			addr(ID, tg[i], 1'b0, 1'b1);
			repeat (2) wr(8'($urandom), 1'b1);
			fin();
		end
		chk({7'h00, standby}, 8'h00);
		addr(~ID, 3'h0, 1'b0, 1'b0);
		wr(8'h5a, 1'b0);
		fin();
		@(negedge clk) write_busy = 1'b1;
		addr(ID, 3'h7, 1'b0, 1'b0);
		fin();
		@(negedge clk) write_busy = 1'b0;
		addr(ID, 3'h7, 1'b1, 1'b1);
		rd(1'b0);
		rd(1'b0);
		rd(1'b1);
		i_mst.xfer(8'hff, 1'b1, q, a);
		chk(q, 8'hff);
		fin();
		repeat (8) @(negedge clk);
		chk({7'h00, standby}, 8'h01);
		addr(ID, 3'h2, 1'b0, 1'b1);
		wr(8'($urandom), 1'b1);
		addr(ID, 3'h2, 1'b1, 1'b1);
		rd(1'b1);
		fin();
		repeat (10) @(negedge clk);
		chk(8'(rxq.size()), 8'(expd.size()));
		while (expd.size() > 0 && rxq.size() > 0) chk(rxq.pop_front(), expd.pop_front());
		chk(8'(adq.size()), 8'(expa.size()));
		while (expa.size() > 0 && adq.size() > 0) chk(adq.pop_front(), expa.pop_front());
		chk(8'(n_st), 8'(es));
		chk(8'(n_en), 8'(ee));
		wrap_up();
	end
endmodule
